/* File: include/fdo_pkg.sv */
// constants and types for the fractional divider output stage
package fdo_pkg;
  localparam int NUM_DIV = 8;
  localparam int NUM_PATH = 12;
  localparam int FRAC_W = 43;
  localparam int INT_W = 8;
  localparam int CNT_W = 10;
  // synthesizer clock period as seen by this model, in ps
  localparam int SYNTH_PERIOD_PS = 8000;
  // fraction units per picosecond of phase
  localparam longint FRAC_PER_PS = (64'h1 << FRAC_W) / SYNTH_PERIOD_PS;
  // phase step per divider period, in ps, for each rate
  localparam logic [31:0] STEP_SLOW_PS = 32'h1;
  localparam logic [31:0] STEP_MEDIUM_PS = 32'h8;
  localparam logic [31:0] STEP_FAST_PS = 32'h40;
  typedef enum logic [1:0] {
    RATE_SLOW = 2'b00,
    RATE_MEDIUM = 2'b01,
    RATE_FAST = 2'b10
  } fdo_rate_type;
  // register word indices
  localparam logic [7:0] DIV_STRIDE = 8'h08;
  localparam logic [7:0] F_WHOLE = 8'h0;
  localparam logic [7:0] F_FRAC_LO = 8'h1;
  localparam logic [7:0] F_FRAC_HI = 8'h2;
  localparam logic [7:0] F_PHASE = 8'h3;
  localparam logic [7:0] F_RATE = 8'h4;
  localparam logic [7:0] F_PENDING = 8'h5;
  localparam logic [7:0] PATH_BASE = 8'h40;
  localparam logic [7:0] PATH_STRIDE = 8'h04;
  localparam logic [7:0] F_RATIO = 8'h0;
  localparam logic [7:0] F_WIDTH = 8'h1;
  localparam logic [7:0] F_CTRL = 8'h2;
  localparam logic [7:0] MUX_IDX = 8'h70;
  // reset values
  localparam logic [INT_W-1:0] WHOLE_RST = 8'h14;
  localparam logic [FRAC_W-1:0] FRAC_RST = 43'h0;
  localparam logic [31:0] RATIO_RST = 32'h2;
  localparam logic [31:0] WIDTH_RST = 32'h0;
  typedef struct packed {
    logic [INT_W-1:0] whole;
    logic [FRAC_W-1:0] frac;
    fdo_rate_type rate;
    logic signed [31:0] pendPs;
    logic [FRAC_W-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic tick;
  } fdo_div_type;
  typedef struct packed {
    logic [31:0] ratio;
    logic [31:0] width;
    logic invert;
  } fdo_path_cfg_type;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic [31:0] data;
  } fdo_reg_req_type;
endpackage

/* File: rtl/fdo_out_path.sv */
// one output path: integer divider with duty control
`timescale 1ns/1ps
module fdo_out_path
  import fdo_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic tick, // divider clock enable
  input wire fdo_path_cfg_type cfg, // ratio, width, invert
  output logic trueOut, // true output pin level
  output logic compOut // complementary output pin level
);
  typedef struct packed {
    logic [31:0] cnt;
    logic level;
  } fdo_path_st_type;
  fdo_path_st_type st_q, st_d;
  logic [31:0] highCnt;
  logic [31:0] cntNext;

  always_comb
  begin
    st_d = st_q;
    // zero width gives half duty, odd ratio high shorter
    if (cfg.width == 32'h0)
      highCnt = cfg.ratio >> 1;
    else
      highCnt = cfg.width;
    if (highCnt == 32'h0)
      highCnt = 32'h1;
    if (st_q.cnt + 32'h1 >= cfg.ratio)
      cntNext = 32'h0;
    else
      cntNext = st_q.cnt + 32'h1;
    if (tick)
    begin
      st_d.cnt = cntNext;
      st_d.level = cntNext < highCnt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign trueOut = st_q.level;
  assign compOut = cfg.invert ? ~st_q.level : st_q.level;

  property p_wrap;
    @(posedge clk) disable iff (rst)
      (tick && cfg.ratio > 32'h1 && st_q.cnt == cfg.ratio - 32'h1)
      |=> (st_q.cnt == 32'h0 && st_q.level);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("output counter did not wrap high");

  property p_width;
    @(posedge clk) disable iff (rst)
      (tick && cfg.width != 32'h0 && cfg.width < cfg.ratio
       && st_q.cnt + 32'h1 == cfg.width) |=> !st_q.level;
  endproperty
  a_width: assert property (p_width)
    else $error("high pulse longer than programmed width");

  property p_half;
    @(posedge clk) disable iff (rst)
      (tick && cfg.width == 32'h0 && cfg.ratio > 32'h1
       && st_q.cnt + 32'h1 == (cfg.ratio >> 1)) |=> !st_q.level;
  endproperty
  a_half: assert property (p_half)
    else $error("default duty high phase wrong length");

  property p_hold;
    @(posedge clk) disable iff (rst)
      !tick |=> $stable(st_q.level);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output moved without divider clock");
endmodule

/* File: rtl/fdo_output_stage.sv */
// fractional dividers, source mapping and output paths
`timescale 1ns/1ps
// Summary of operation
// - divider ratio is whole part plus 43-bit fraction over two to the 43.
// - each divider clock feeds its output stages and the lock loop feedback.
// - fine phase shift raises or lowers divider frequency for a while.
// - signed picosecond value; negative advances edges, positive delays them.
// - slow, medium, fast rate pick size and length of frequency change.
// - successive phase requests accumulate without limit.
// - stages 0-3 dual from same index; 4 picks 4/5, 7 picks 6/7.
// - dual stage holds two identical paths from the same divider clock.
// - each path divides its divider clock by a 32-bit integer.
// - default output duty cycle is half high, half low.
// - programmed width sets high time in divider cycles, rest low.
// - zero width selects the default half duty cycle.
// - pulses are high-going; low-going via inverted complementary pin.
// - width and duty controls work in every mode.
module fdo_output_stage
  import fdo_pkg::*;
(
  input wire logic clk, // synthesizer clock
  input wire logic rst, // async reset, active high
  input wire fdo_reg_req_type req, // register write/read request
  output logic [31:0] rdData, // read data, one cycle after rd
  output logic [NUM_DIV-1:0] divTick, // divider clocks to lock loop
  output logic [NUM_PATH-1:0] trueOutPin, // true output pins
  output logic [NUM_PATH-1:0] compOutPin // complementary output pins
);
  typedef struct packed {
    fdo_div_type [NUM_DIV-1:0] div;
    fdo_path_cfg_type [NUM_PATH-1:0] path;
    logic stage4Sel;
    logic stage7Sel;
    logic dualSplit;
    logic [31:0] rdData;
  } fdo_stage_st_type;
  fdo_stage_st_type st_q, st_d;
  logic [NUM_PATH-1:0] pathTick;

  function automatic logic signed [31:0] stepOf(fdo_rate_type r);
    unique case (r)
      RATE_SLOW: stepOf = STEP_SLOW_PS;
      RATE_MEDIUM: stepOf = STEP_MEDIUM_PS;
      RATE_FAST: stepOf = STEP_FAST_PS;
      default: stepOf = STEP_SLOW_PS;
    endcase
  endfunction

  always_comb
  begin
    logic signed [31:0] step;
    logic signed [31:0] chunk;
    logic signed [63:0] sum;
    logic signed [63:0] period;
    logic [7:0] base;
    step = '0;
    chunk = '0;
    sum = '0;
    period = '0;
    base = '0;
    st_d = st_q;
    for (int d = 0; d < NUM_DIV; d++)
    begin
      base = 8'(d) * DIV_STRIDE;
      st_d.div[d].tick = 1'b0;
      if (st_q.div[d].cnt == '0)
      begin
        // close one divider period; fold phase chunk into it
        step = stepOf(st_q.div[d].rate);
        if (st_q.div[d].pendPs > step)
          chunk = step;
        else if (st_q.div[d].pendPs < -step)
          chunk = -step;
        else
          chunk = st_q.div[d].pendPs;
        // positive pending lengthens periods, delaying edges
        sum = 64'(st_q.div[d].acc) + 64'(st_q.div[d].frac)
              + 64'(chunk) * FRAC_PER_PS;
        period = 64'(st_q.div[d].whole) + (sum >>> FRAC_W);
        st_d.div[d].acc = sum[FRAC_W-1:0];
        st_d.div[d].cnt = CNT_W'(period - 64'sh1);
        st_d.div[d].pendPs = st_q.div[d].pendPs - chunk;
        st_d.div[d].tick = 1'b1;
      end
      else
      begin
        st_d.div[d].cnt = st_q.div[d].cnt - CNT_W'(1);
      end
      if (req.wr)
      begin
        if (req.idx == base + F_WHOLE)
          st_d.div[d].whole = req.data[INT_W-1:0];
        if (req.idx == base + F_FRAC_LO)
          st_d.div[d].frac[31:0] = req.data;
        if (req.idx == base + F_FRAC_HI)
          st_d.div[d].frac[FRAC_W-1:32] = req.data[FRAC_W-33:0];
        if (req.idx == base + F_PHASE)
          st_d.div[d].pendPs = st_d.div[d].pendPs
                               + $signed(req.data);
        if (req.idx == base + F_RATE)
          st_d.div[d].rate = fdo_rate_type'(req.data[1:0]);
      end
    end
    for (int p = 0; p < NUM_PATH; p++)
    begin
      base = PATH_BASE + 8'(p) * PATH_STRIDE;
      if (req.wr && req.idx == base + F_RATIO)
        st_d.path[p].ratio = req.data;
      if (req.wr && req.idx == base + F_WIDTH)
        st_d.path[p].width = req.data;
      if (req.wr && req.idx == base + F_CTRL)
        st_d.path[p].invert = req.data[0];
    end
    if (req.wr && req.idx == MUX_IDX)
    begin
      st_d.stage4Sel = req.data[0];
      st_d.stage7Sel = req.data[1];
    end
    // sticky once the two copies of dual stage 0 were set apart
    st_d.dualSplit = st_q.dualSplit | (st_q.path[0] != st_q.path[1]);
    if (req.rd)
    begin
      st_d.rdData = '0;
      for (int d = 0; d < NUM_DIV; d++)
      begin
        base = 8'(d) * DIV_STRIDE;
        if (req.idx == base + F_WHOLE)
          st_d.rdData = 32'(st_q.div[d].whole);
        if (req.idx == base + F_FRAC_LO)
          st_d.rdData = st_q.div[d].frac[31:0];
        if (req.idx == base + F_FRAC_HI)
          st_d.rdData = 32'(st_q.div[d].frac[FRAC_W-1:32]);
        if (req.idx == base + F_RATE)
          st_d.rdData = 32'(st_q.div[d].rate);
        if (req.idx == base + F_PENDING)
          st_d.rdData = st_q.div[d].pendPs;
      end
      for (int p = 0; p < NUM_PATH; p++)
      begin
        base = PATH_BASE + 8'(p) * PATH_STRIDE;
        if (req.idx == base + F_RATIO)
          st_d.rdData = st_q.path[p].ratio;
        if (req.idx == base + F_WIDTH)
          st_d.rdData = st_q.path[p].width;
        if (req.idx == base + F_CTRL)
          st_d.rdData = 32'(st_q.path[p].invert);
      end
      if (req.idx == MUX_IDX)
        st_d.rdData = {30'h0, st_q.stage7Sel, st_q.stage4Sel};
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= '0;
      for (int d = 0; d < NUM_DIV; d++)
      begin
        st_q.div[d].whole <= WHOLE_RST;
        st_q.div[d].frac <= FRAC_RST;
        st_q.div[d].rate <= RATE_SLOW;
      end
      for (int p = 0; p < NUM_PATH; p++)
      begin
        st_q.path[p].ratio <= RATIO_RST;
        st_q.path[p].width <= WIDTH_RST;
      end
    end
    else
      st_q <= st_d;
  end

  assign rdData = st_q.rdData;

  generate
    for (genvar d = 0; d < NUM_DIV; d++)
    begin : g_tick
      assign divTick[d] = st_q.div[d].tick;
    end
  endgenerate

  // paths 0..7 pair up into dual stages 0..3
  generate
    for (genvar p = 0; p < NUM_PATH; p++)
    begin : g_path
      if (p < 8)
      begin : g_dual
        assign pathTick[p] = divTick[p/2];
      end
      else if (p == 8)
      begin : g_s4
        assign pathTick[p] = st_q.stage4Sel ? divTick[5] : divTick[4];
      end
      else if (p == 11)
      begin : g_s7
        assign pathTick[p] = st_q.stage7Sel ? divTick[7] : divTick[6];
      end
      else
      begin : g_fixed
        assign pathTick[p] = divTick[p-4];
      end
      fdo_out_path u_path (
        .clk(clk),
        .rst(rst),
        .tick(pathTick[p]),
        .cfg(st_q.path[p]),
        .trueOut(trueOutPin[p]),
        .compOut(compOutPin[p])
      );
    end
  endgenerate

  property p_tickPeriod;
    @(posedge clk) disable iff (rst)
      (st_q.div[0].cnt == '0 && st_q.div[0].pendPs == 32'sh0
       && st_q.div[0].frac == '0 && st_q.div[0].acc == '0 && !req.wr)
      |=> st_q.div[0].cnt == CNT_W'(st_q.div[0].whole) - CNT_W'(1);
  endproperty
  a_tickPeriod: assert property (p_tickPeriod)
    else $error("integer divider period wrong");

  property p_accum;
    @(posedge clk) disable iff (rst)
      (req.wr && req.idx == F_PHASE && !divTick[0] && st_q.div[0].cnt != '0)
      |=> st_q.div[0].pendPs == $past(st_q.div[0].pendPs)
          + $signed($past(req.data));
  endproperty
  a_accum: assert property (p_accum)
    else $error("phase request not accumulated");

  property p_fastStep;
    @(posedge clk) disable iff (rst)
      (st_q.div[0].cnt == '0 && st_q.div[0].rate == RATE_FAST
       && st_q.div[0].pendPs > 32'sh40 && !req.wr)
      |=> st_q.div[0].pendPs == $past(st_q.div[0].pendPs) - 32'sh40;
  endproperty
  a_fastStep: assert property (p_fastStep)
    else $error("fast rate step wrong");

  property p_mux4;
    @(posedge clk) disable iff (rst)
      st_q.stage4Sel |-> pathTick[8] == divTick[5];
  endproperty
  a_mux4: assert property (p_mux4)
    else $error("stage 4 source select ignored");

  property p_dual;
    @(posedge clk) disable iff (rst)
      !st_q.dualSplit |-> trueOutPin[0] == trueOutPin[1];
  endproperty
  a_dual: assert property (p_dual)
    else $error("dual stage copies diverged");
endmodule

/* File: testbench/fdo_clock_sink.sv */
// downstream receiver measuring one output clock
`timescale 1ns/1ps
module fdo_clock_sink
(
  input wire logic clk, // sampling clock
  input wire logic rst, // async reset, active high
  input wire logic pin, // received clock level
  output int hiLen, // last high time, cycles
  output int perLen, // last period, cycles
  output int rises // rising edges seen
);
  int cnt;
  logic pinQ;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt <= 0;
      pinQ <= 1'b0;
      hiLen <= 0;
      perLen <= 0;
      rises <= 0;
    end
    else
    begin
      pinQ <= pin;
      cnt <= (pin && !pinQ) ? 1 : cnt + 1;
      if (pin && !pinQ)
      begin
        perLen <= cnt;
        rises <= rises + 1;
      end
      if (!pin && pinQ)
        hiLen <= cnt;
    end
  end
endmodule

/* File: testbench/fdo_output_stage_bench.sv */
// self-checking bench for the divider output stage
`timescale 1ns/1ps
module fdo_output_stage_bench
  import fdo_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  fdo_reg_req_type req = '0;
  logic [31:0] rdData;
  logic [NUM_DIV-1:0] divTick;
  logic [NUM_PATH-1:0] trueOutPin;
  logic [NUM_PATH-1:0] compOutPin;
  logic [19:0] src;
  int sel = 0;
  int hiLen;
  int perLen;
  int rises;
  int miscompares = 0;
  int compares = 0;
  int ticks = 0;
  logic [31:0] rng = 32'h43;
  logic [31:0] mdl [256];
  assign src = {divTick, trueOutPin};
  always #4 clk = ~clk;
  always @(posedge clk)
    if (divTick[0] === 1'b1)
      ticks++;
  fdo_output_stage fdo_output_stage_i (.clk(clk), .rst(rst), .req(req),
    .rdData(rdData), .divTick(divTick), .trueOutPin(trueOutPin),
    .compOutPin(compOutPin));
  fdo_clock_sink fdo_clock_sink_i (.clk(clk), .rst(rst), .pin(src[sel]),
    .hiLen(hiLen), .perLen(perLen), .rises(rises));
////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chkReg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkLen(input int got, input int exp);
    compares++;
    if (got != exp)
    begin
      miscompares++;
      $display("[ERR] %0t len got %0h exp %0h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  // bits of each word that read back as written, zero where unmapped
  function automatic logic [31:0] msk(input logic [7:0] i);
    if (i < PATH_BASE)
      case (i[2:0])
        3'h0: return 32'hFF;
        3'h1: return 32'hFFFFFFFF;
        3'h2: return 32'h7FF;
        3'h4: return 32'h3;
        default: return 32'h0;
      endcase
    if (i < MUX_IDX)
      return (i[1:0] == 2'h2) ? 32'h1 : (i[1] ? 32'h0 : 32'hFFFFFFFF);
    return (i == MUX_IDX) ? 32'h3 : 32'h0;
  endfunction
  task automatic rstPulse();
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (mdl[k])
      mdl[k] = (k < 64 && k % 8 == 0) ? {24'h0, WHOLE_RST} :
        ((k >= 64 && k < 112 && k % 4 == 0) ? RATIO_RST : 32'h0);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    req.wr <= 1'b1;
    req.idx <= i;
    req.data <= d;
    @(posedge clk);
    req.wr <= 1'b0;
    mdl[i] = d & msk(i);
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d);
    req.rd <= 1'b1;
    req.idx <= i;
    @(posedge clk);
    req.rd <= 1'b0;
    @(posedge clk);
    d = rdData;
  endtask
  task automatic readAll();
    logic [31:0] v;
    for (int k = 0; k < 256; k++)
    begin
      rd(k[7:0], v);
      chkReg(v, mdl[k]);
    end
  endtask
  task automatic waitRise(input int n);
    int r0;
    r0 = rises;
    for (int k = 0; k < 5000 && rises < r0 + n; k++)
      @(posedge clk);
    if (rises < r0 + n)
    begin
      miscompares++;
      end_sim();
    end
  endtask
  task automatic drain(input int t0, input int n);
    logic [31:0] v;
    int t;
    v = 32'h1;
    for (int k = 0; k < 3000 && v !== 32'h0; k++)
      rd(F_PENDING, v);
    chkReg(v, 32'h0);
    t = ticks - t0;
    chkLen((t >= n && t <= n + 2) ? n : t, n);
  endtask
////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] v;
    int r;
    int w;
    int t0;
    time s;
    rstPulse();
    readAll();
    for (int k = 0; k < 256; k++)
      if (k >= 64 || (k % 8 != 3 && k % 8 != 5))
        wr(k[7:0], xs());
    readAll();
    rstPulse();
    readAll();
    wr(F_WHOLE, 32'hE);
    sel = 12;
    waitRise(4);
    chkLen(perLen, 14);
    wr(F_FRAC_HI, 32'h400);
    waitRise(2);
    s = $time;
    waitRise(8);
    chkLen(int'(($time - s) / 8), 116);
    wr(F_FRAC_HI, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      r = (c == 0) ? 4 : ((c == 1) ? 5 : 3 + xs() % 8);
      w = (c < 2) ? 0 : xs() % r;
      for (int p = 0; p < 2; p++)
      begin
        wr(PATH_BASE + 8'(p * 4), r);
        wr(PATH_BASE + 8'(p * 4 + 1), w);
        sel = p;
        waitRise(4);
        chkLen(perLen, r * 14);
        chkLen(hiLen, 14 * (w != 0 ? w : r / 2));
      end
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(PATH_BASE + F_CTRL, b);
      repeat (40)
      begin
        @(negedge clk);
        chkReg(compOutPin[0], trueOutPin[0] ^ b[0]);
      end
      @(posedge clk);
    end
    wr(8'h20, 32'hE);
    wr(8'h30, 32'hE);
    for (int b = 0; b < 2; b++)
    begin
      wr(MUX_IDX, b * 3);
      sel = 8;
      waitRise(4);
      chkLen(perLen, b ? 40 : 28);
      sel = 11;
      waitRise(4);
      chkLen(perLen, b ? 40 : 28);
    end
    for (int p = 2; p < 11; p++)
    begin
      if (p < 8)
        wr(8'(p / 2 * 8), 14 + p / 2);
      sel = p;
      waitRise(4);
      chkLen(perLen, p < 8 ? 28 + p / 2 * 2 : (p == 10 ? 28 : 40));
    end
    for (int q = 0; q < 3; q++)
    begin
      wr(F_RATE, q);
      t0 = ticks;
      wr(F_PHASE, 100);
      wr(F_PHASE, 100);
      drain(t0, q == 0 ? 200 : (q == 1 ? 25 : 4));
    end
    t0 = ticks;
    wr(F_PHASE, -200);
    rd(F_PENDING, v);
    chkReg(v[31], 1'b1);
    drain(t0, 4);
    end_sim();
  end
endmodule
